// File: verif/line_pullup_model.sv
// Open-drain data line with its pull-up, as seen by the far side.
// Assumes the master drives only low, through its output enable.
`timescale 1ns/1ps

module line_pullup_model (
  // Master pin
  input wire logic i_dq_out,
  input wire logic i_dq_oe,
  // Resolved line
  output logic o_level
);
  // Released line floats back to high
  assign o_level = (i_dq_oe && !i_dq_out) ? 1'b0 : 1'b1;
endmodule

// File: verif/single_wire_clock_divider_reset_tb_top.sv
// Self-checking bench for the timebase and soft-reset block.
// Assumes a 40 MHz bus clock and registers at the design's offsets.
`timescale 1ns/1ps
`include "swd_params.svh"

module single_wire_clock_divider_reset_tb_top;
  import swd_pkg::*;
  logic i_mclk, i_srst, i_wr_en, i_rd_en, lock, drive_low;
  logic [`SWD_ADDR_W-1:0] i_addr;
  reg_word_t i_wdata, o_rdata, d;
  logic o_tick, o_sm_reset, o_dq_out, o_dq_oe, line;
  int err_count, n_tests, seed, n, i, bad;
  logic [7:0] f;
  logic [7:0] factors [5];

  single_wire_clock_divider_reset DUT (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_clock_lock_indication(lock), .i_line_drive_low(drive_low),
    .o_tick(o_tick), .o_sm_reset(o_sm_reset), .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe));
  line_pullup_model far_end (.i_dq_out(o_dq_out), .i_dq_oe(o_dq_oe),
    .o_level(line));

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic reg_word_t gap_of(logic [7:0] fct);
    return {8'h00, fct} + 16'h0001;
  endfunction

  task automatic check(input reg_word_t seen, input reg_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input reg_word_t v);
    @(posedge i_mclk);
    #2;
    i_addr = a;
    i_wdata = v;
    i_wr_en = 1'b1;
    @(posedge i_mclk);
    #2;
    i_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input reg_word_t exp);
    @(posedge i_mclk);
    #2;
    i_addr = a;
    i_rd_en = 1'b1;
    @(posedge i_mclk);
    #2;
    i_rd_en = 1'b0;
    check(o_rdata, exp);
  endtask

  // Cycles until the next tick, bounded
  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(posedge i_mclk);
      #2;
      cnt++;
    end while (o_tick !== 1'b1 && cnt < 600);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    err_count++;
    conclude();
  end

  initial begin
    seed = 32'h653f;
    {i_wr_en, i_rd_en, lock, drive_low} = 4'h0;
    i_addr = 3'h0;
    i_wdata = 16'h0000;
    i_srst = 1'b1;
    repeat (3) @(posedge i_mclk);
    #2;
    i_srst = 1'b0;
    lock = 1'b1;
    repeat (6) @(posedge i_mclk);
    #2;
    check({15'h0000, o_sm_reset}, 16'h0000);
    rd(`SWD_OFS_DIVIDE, 16'h0000);
    rd(`SWD_OFS_RESET, 16'h0000);
    rd(3'h6, 16'h0000);
    wr(3'h6, 16'hffff);
    rd(`SWD_OFS_RESET, 16'h0000);
    rd(`SWD_OFS_DIVIDE, 16'h0000);
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      wr(`SWD_OFS_DIVIDE, d);
      rd(`SWD_OFS_DIVIDE, d & 16'h00ff);
    end
    d = 16'($random(seed));
    factors = '{8'h00, 8'h01, 8'h02, 8'hff, d[7:0] & 8'h1f};
    for (i = 0; i < 5; i++) begin
      f = factors[i];
      wr(`SWD_OFS_DIVIDE, {d[15:8], f});
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      check(n[15:0], gap_of(f));
    end
    // Software picks the factor nearest 1 MHz
    wr(`SWD_OFS_DIVIDE, 16'h0027);
    drive_low = 1'b1;
    repeat (2) @(posedge i_mclk);
    #2;
    check({15'h0000, line}, 16'h0000);
    wr(`SWD_OFS_RESET, 16'hffff);
    @(posedge i_mclk);
    #2;
    check({14'h0000, o_sm_reset, line}, 16'h0003);
    bad = 0;
    repeat (300) begin
      @(posedge i_mclk);
      #2;
      if (o_tick !== 1'b0 || o_sm_reset !== 1'b1 || o_dq_oe !== 1'b0)
        bad++;
    end
    check(bad[15:0], 16'h0000);
    rd(`SWD_OFS_RESET, 16'h0001);
    wr(`SWD_OFS_RESET, 16'hfffe);
    @(posedge i_mclk);
    #2;
    check({14'h0000, o_sm_reset, line}, 16'h0000);
    wait_tick(n);
    wait_tick(n);
    check(n[15:0], 16'(`SWD_TICK_CYC));
    drive_low = 1'b0;
    i_srst = 1'b1;
    repeat (3) @(posedge i_mclk);
    #2;
    i_srst = 1'b0;
    rd(`SWD_OFS_DIVIDE, 16'h0000);
    conclude();
  end
endmodule

// File: verilog/bus_tick_divider.sv
// Divides the bus clock by factor plus one into a one-cycle tick.
// Assumes factor and hold come from logic on the same clock.
`timescale 1ns/1ps

module bus_tick_divider
  import swd_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Owner side
  tick_if.divider tk
);

  logic [DIV_W-1:0] cnt;
  logic tick_q;

  assign tk.tick = tick_q;

  ////////////////////////////////////////////////////////////////////////
  // Counter: period is factor plus one bus clocks
  always_ff @(posedge i_mclk) begin
    if (i_srst || tk.hold) begin
      cnt <= '0;
      tick_q <= 1'b0;
    end else if (cnt >= tk.factor) begin
      cnt <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [DIV_W:0] gap;
  logic steady;
  logic [DIV_W-1:0] last_factor;

  always_ff @(posedge i_mclk) begin
    if (i_srst || tk.hold) begin
      gap <= '0;
      steady <= 1'b0;
      last_factor <= '0;
    end else begin
      last_factor <= tk.factor;
      if (tk.factor != last_factor) begin
        steady <= 1'b0;
      end else if (tick_q) begin
        steady <= 1'b1;
      end
      gap <= tick_q ? {{DIV_W{1'b0}}, 1'b1} : gap + 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  property p_tick_period;
    tick_q && steady && tk.factor == last_factor && !tk.hold
      |-> gap == {1'b0, tk.factor} + 1'b1;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick period differs from factor plus one");

  property p_div_by_one;
    !tk.hold && tk.factor == '0 ##1 !tk.hold && tk.factor == '0 |-> tick_q;
  endproperty
  a_div_by_one: assert property (p_div_by_one)
    else $error("factor zero must tick every cycle");

  property p_hold_stops;
    tk.hold |=> !tick_q;
  endproperty
  a_hold_stops: assert property (p_hold_stops)
    else $error("tick issued while held");

  c_full_range: cover property (tick_q && tk.factor == 8'hff && steady);
endmodule

// File: verilog/single_wire_clock_divider_reset.sv
// Timebase and software reset of an on-chip single-wire bus master.
// Assumes a 16-bit register port on the bus clock, and a bus state
// machine elsewhere that uses o_tick as its timing and o_sm_reset.
`timescale 1ns/1ps
`include "swd_params.svh"

module single_wire_clock_divider_reset
  import swd_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Register port, 16-bit accesses
  input wire logic [`SWD_ADDR_W-1:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // Source clock status
  input wire logic i_clock_lock_indication,
  // Bus state machine side
  input wire logic i_line_drive_low,
  output logic o_tick,
  output logic o_sm_reset,
  // Open-drain data line
  output logic o_dq_out,
  output logic o_dq_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic reg_sel_t decode_sel(
    input logic [`SWD_ADDR_W-1:0] addr
  );
    reg_sel_t sel;
    if (addr == `SWD_OFS_DIVIDE) begin
      sel = SEL_DIV;
    end else if (addr == `SWD_OFS_RESET) begin
      sel = SEL_RST;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  assign wr_sel = decode_sel(i_addr);
  assign rd_sel = wr_sel;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [DIV_W-1:0] divide_factor;
  logic soft_rst;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      divide_factor <= `SWD_DIV_RST;
    end else if (i_wr_en && wr_sel == SEL_DIV) begin
      divide_factor <= i_wdata[`SWD_DIV_MSB:`SWD_DIV_LSB];
    end
  end

  // No self-clear: stays set until software writes zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      soft_rst <= `SWD_RST_RST;
    end else if (i_wr_en && wr_sel == SEL_RST) begin
      soft_rst <= i_wdata[`SWD_RST_BIT];
    end
  end

  // Read data, reserved bits zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= `SWD_WORD_ZERO;
    end else if (i_rd_en) begin
      if (rd_sel == SEL_DIV) begin
        o_rdata <= {{(16 - DIV_W){1'b0}}, divide_factor};
      end else if (rd_sel == SEL_RST) begin
        o_rdata <= {15'h0000, soft_rst};
      end else begin
        o_rdata <= `SWD_WORD_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock status synchroniser
  logic [2:0] lock_sync;
  logic lock_ok;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      lock_sync <= 3'h0;
    end else begin
      lock_sync <= {lock_sync[1:0], i_clock_lock_indication};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      lock_ok <= 1'b0;
    end else if (lock_sync[1] == lock_sync[2]) begin
      lock_ok <= lock_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timebase: restarts in phase when soft reset is released
  tick_if #(.DIV_W(DIV_W)) tk ();

  assign tk.factor = divide_factor;
  assign tk.hold = soft_rst || !lock_ok;

  bus_tick_divider #(.DIV_W(DIV_W)) u_div (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .tk(tk)
  );

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= tk.tick;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_sm_reset <= 1'b1;
    end else begin
      o_sm_reset <= soft_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line driver: only pulls low, soft reset releases it one clock after the bit sets
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_dq_oe <= 1'b0;
      o_dq_out <= 1'b0;
    end else begin
      o_dq_oe <= i_line_drive_low && !soft_rst;
      o_dq_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  property p_div_reserved;
    i_rd_en && i_addr == `SWD_OFS_DIVIDE
      |=> o_rdata[15:8] == 8'h00 && o_rdata[7:0] == $past(divide_factor);
  endproperty
  a_div_reserved: assert property (p_div_reserved)
    else $error("divide register read data wrong");

  property p_rst_write;
    i_wr_en && i_addr == `SWD_OFS_RESET
      |-> ##2 o_sm_reset == $past(i_wdata[0], 2);
  endproperty
  a_rst_write: assert property (p_rst_write)
    else $error("state machine reset does not follow written bit");

  property p_abort;
    soft_rst |=> !o_dq_oe;
  endproperty
  a_abort: assert property (p_abort)
    else $error("line driven during soft reset");

  // Tick lags the hold by the divider flop and the output flop
  property p_abort_tick;
    soft_rst |-> ##2 !o_tick;
  endproperty
  a_abort_tick: assert property (p_abort_tick)
    else $error("tick issued during soft reset");

  property p_line_follow;
    i_line_drive_low && !soft_rst |=> o_dq_oe;
  endproperty
  a_line_follow: assert property (p_line_follow)
    else $error("line not pulled low when asked");

  property p_rst_reserved;
    i_rd_en && i_addr == `SWD_OFS_RESET
      |=> o_rdata[15:1] == 15'h0000 && o_rdata[0] == $past(soft_rst);
  endproperty
  a_rst_reserved: assert property (p_rst_reserved)
    else $error("reset register read data wrong");

  property p_rst_sticky;
    soft_rst && !(i_wr_en && i_addr == `SWD_OFS_RESET) |=> soft_rst;
  endproperty
  a_rst_sticky: assert property (p_rst_sticky)
    else $error("soft reset bit cleared without a write");

  property p_tick_needs_run;
    o_tick |-> $past(lock_ok, 2) && !$past(soft_rst, 2);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run)
    else $error("tick without lock or while in reset");

  c_one_mhz: cover property (
    o_tick && divide_factor == DIV_W'(`SWD_TICK_CYC - 1));
  c_soft_reset: cover property (
    i_wr_en && i_addr == `SWD_OFS_RESET && i_wdata[0]);
  c_abort_drive: cover property (i_line_drive_low && soft_rst && o_dq_oe);
endmodule

// File: verilog/swd_params.svh
// Constants for the single-wire timebase and soft-reset block.
// Assumes 16-bit register accesses at byte offsets from the block base.
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH

// Register offsets (byte address within the block)
`define SWD_ADDR_W 3
`define SWD_OFS_DIVIDE 3'h2
`define SWD_OFS_RESET 3'h4

// Field layout
`define SWD_DIV_MSB 7
`define SWD_DIV_LSB 0
`define SWD_RST_BIT 0

// Reset values
`define SWD_DIV_RST 8'h00
`define SWD_RST_RST 1'b0
`define SWD_WORD_ZERO 16'h0000

// Timing: target module clock period against the bus clock period
`define SWD_TICK_NS 1000
`define SWD_MCLK_NS 25
`define SWD_TICK_CYC ((`SWD_TICK_NS) / (`SWD_MCLK_NS))

`endif

// File: verilog/swd_pkg.sv
// Types shared by the single-wire timebase and soft-reset block.
// Assumes swd_params.svh supplies the numeric constants.
package swd_pkg;

  typedef logic [15:0] reg_word_t;

  // Register selected by an access, one-hot
  typedef enum logic [2:0] {
    SEL_NONE = 3'b001,
    SEL_DIV = 3'b010,
    SEL_RST = 3'b100
  } reg_sel_t;

endpackage

// File: verilog/tick_if.sv
// Link between the register owner and the timebase divider.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps

interface tick_if #(
  parameter int DIV_W = 8
);
  logic [DIV_W-1:0] factor;
  logic hold;
  logic tick;

  modport divider (input factor, input hold, output tick);
  modport owner (output factor, output hold, input tick);
endinterface
